// *** include/smws_pkg.sv ***
// shared constants and types of the stop-mode wake sequencer
package smws_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte addresses
	localparam logic [4:0] ADDR_PROT_CMD = 5'h00;
	localparam logic [4:0] ADDR_PSC = 5'h04;
	localparam logic [4:0] ADDR_OSC_SETTLE_SELECT_REG = 5'h08;
	localparam logic [4:0] ADDR_CFG = 5'h0c;
	localparam logic [4:0] ADDR_STAT = 5'h10;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int PSC_IDLE_POS = 0;
	localparam int PSC_STOP_POS = 1;
	localparam int OSC_SETTLE_SELECT_REG_W = 3;
	localparam int CFG_ASYNC_SERIAL_CH0_EXT_POS = 0;
	localparam int CFG_ASYNC_SERIAL_CH1_EXT_POS = 1;
	localparam int CFG_CLOCKED_SERIAL_CH4_EXT_POS = 2;
	localparam int STAT_STATE_POS = 0;
	localparam int STAT_HAZARD_POS = 4;
	localparam int STAT_PROT_ERR_POS = 5;
	localparam int STAT_WAKE_NMI_POS = 6;
	localparam int STAT_ARMED_POS = 7;

	////////////////////////////////////////////////////////////////////////
	// reset values and timing
	localparam logic [7:0] PSC_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [OSC_SETTLE_SELECT_REG_W-1:0] OSC_SETTLE_SELECT_REG_RST_SHORT = 3'h4;
	localparam logic [OSC_SETTLE_SELECT_REG_W-1:0] OSC_SETTLE_SELECT_REG_RST_LONG = 3'h7;
	localparam logic [4:0] SETTLE_EXP_BASE_DEF = 5'h0e;
	localparam int SETTLE_CNT_W = 22;
	localparam int IRQ_W = 8;
	localparam int UART_N = 2;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_IDLE = 4'h2,
		ST_STOP = 4'h4,
		ST_SETTLE = 4'h8
	} smws_state_t;

	typedef struct packed {
		logic [UART_N-1:0] uart_tx;
		logic [UART_N-1:0] uart_rx;
		logic clocked_serial_ch4;
		logic other;
	} smws_periph_en_t;

	typedef struct packed {
		logic np;
		logic id;
		logic ei_cleared;
	} smws_psw_t;

endpackage : smws_pkg

// *** core/smws_settle_counter.sv ***
// oscillator settling counter, 2^exp periods from a start pulse
`timescale 1ns/100ps
`default_nettype none
module smws_settle_counter
	import smws_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [4:0] exp_sel,
	output logic running,
	output logic done
);

	logic [SETTLE_CNT_W-1:0] cnt_r;
	logic [SETTLE_CNT_W-1:0] limit;
	logic running_r;
	logic done_r;

	assign limit = (22'h1 << exp_sel) - 22'h1;
	assign running = running_r;
	assign done = done_r;

	// a start while running is ignored so a late irq cannot restart it
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt_r <= 22'h0;
			running_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			if (!running_r && start)
			begin
				cnt_r <= 22'h0;
				running_r <= 1'b1;
			end
			else if (running_r)
			begin
				if (cnt_r == limit)
				begin
					running_r <= 1'b0;
					done_r <= 1'b1;
				end
				else
					cnt_r <= cnt_r + 22'h1;
			end
		end
	end

endmodule : smws_settle_counter
`default_nettype wire

// *** core/smws_top.sv ***
// stop/idle entry, protected write and wake sequencing with wishbone regs
//
// Overview of operation
// - setting the stop bit enters stop, only with main clock as cpu clock
// - stop halts main oscillator, cpu and peripheral clocks; subclock runs
// - async serial units run in stop only transmitting, with external clock
// - clocked serial channel 4 runs in stop only with external serial clock
// - stop ends on nmi or an unmasked maskable interrupt
// - interrupt wake starts the watchdog counter as settling timer
// - settling length comes from the settle-select register
// - after settling the clock resumes, then the handler branch follows
// - settle-select reset value gives 2^18 or 2^21 periods per variant
// - instructions after the psc store finish before power save begins
// - external-memory entry, any wake (nmi or irq) and held irq flag a pc hazard
// - irq is held while np or id is set, or ei cleared by lower prio
`timescale 1ns/100ps
`default_nettype none
module smws_top
	import smws_pkg::*;
#(
	parameter bit VARIANT_LONG = 1'b0,
	parameter logic [4:0] SETTLE_EXP_BASE = SETTLE_EXP_BASE_DEF
)
(
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [4:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic CPU_CLK_IS_MAIN,
	input wire logic CPU_QUIESCE,
	input wire logic EXEC_EXT_MEM,
	input wire logic NMI_REQ,
	input wire logic [IRQ_W-1:0] IRQ_REQ,
	input wire logic [IRQ_W-1:0] IRQ_MASK,
	input wire smws_psw_t PSW_IN,
	output logic MAIN_OSC_EN,
	output logic SUB_OSC_EN,
	output logic CPU_CLK_EN,
	output smws_periph_en_t PERIPH_EN,
	output logic VECTOR_GO,
	output logic IRQ_HOLD,
	output logic PC_HAZARD
);

	smws_state_t state_r;
	smws_state_t state_nxt;
	logic ack_r;
	logic [31:0] dat_r;
	logic [7:0] psc_r;
	logic [7:0] cfg_r;
	logic [OSC_SETTLE_SELECT_REG_W-1:0] osc_settle_select_reg_r;
	logic armed_r;
	logic prot_err_r;
	logic entry_pend_r;
	logic from_ext_r;
	logic wake_nmi_r;
	logic vec_pend_r;
	logic resume_r;
	logic hazard_r;
	logic wb_req;
	logic wr_strobe;
	logic wake;
	logic irq_wake;
	logic settle_start;
	logic settle_done;
	logic settle_run;
	logic [4:0] settle_exp;
	logic enter_stop;
	logic enter_idle;
	logic resume;

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: one wait state, ack dropped after one cycle
	assign wb_req = WB_CYC_I && WB_STB_I && !ack_r;
	assign wr_strobe = wb_req && WB_WE_I && WB_SEL_I[0];
	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = dat_r;

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			ack_r <= 1'b0;
		else
			ack_r <= wb_req;
	end

	// unmapped addresses ack with zero
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			dat_r <= 32'h0;
		else if (wb_req && !WB_WE_I)
		begin
			unique case (WB_ADR_I)
				ADDR_PSC: dat_r <= {24'h0, psc_r};
				ADDR_OSC_SETTLE_SELECT_REG: dat_r <= {29'h0, osc_settle_select_reg_r};
				ADDR_CFG: dat_r <= {24'h0, cfg_r};
				ADDR_STAT: dat_r <= {24'h0, armed_r, wake_nmi_r, prot_err_r,
					hazard_r, state_r};
				default: dat_r <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// protected write: only the write right after the command write counts
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			armed_r <= 1'b0;
		else if (wr_strobe)
			armed_r <= (WB_ADR_I == ADDR_PROT_CMD);
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			prot_err_r <= 1'b0;
		else if (wr_strobe && WB_ADR_I == ADDR_PSC && !armed_r)
			prot_err_r <= 1'b1;
		else if (wr_strobe && WB_ADR_I == ADDR_STAT && WB_DAT_I[STAT_PROT_ERR_POS])
			prot_err_r <= 1'b0;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			psc_r <= PSC_RST;
		else if (wr_strobe && WB_ADR_I == ADDR_PSC && armed_r)
			psc_r <= WB_DAT_I[7:0];
		else if (resume)
			psc_r <= PSC_RST;
	end

	// settle select is a plain register; reset value per variant
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			osc_settle_select_reg_r <= VARIANT_LONG ? OSC_SETTLE_SELECT_REG_RST_LONG : OSC_SETTLE_SELECT_REG_RST_SHORT;
		else if (wr_strobe && WB_ADR_I == ADDR_OSC_SETTLE_SELECT_REG)
			osc_settle_select_reg_r <= WB_DAT_I[OSC_SETTLE_SELECT_REG_W-1:0];
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			cfg_r <= CFG_RST;
		else if (wr_strobe && WB_ADR_I == ADDR_CFG)
			cfg_r <= WB_DAT_I[7:0];
	end

	////////////////////////////////////////////////////////////////////////
	// entry waits for the cpu to drain the instructions after the store
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			entry_pend_r <= 1'b0;
		else if (wr_strobe && WB_ADR_I == ADDR_PSC && armed_r)
			entry_pend_r <= WB_DAT_I[PSC_IDLE_POS] || WB_DAT_I[PSC_STOP_POS];
		else if (enter_stop || enter_idle || resume)
			entry_pend_r <= 1'b0;
	end

	// stop is refused (stays pending) while the subclock drives the cpu
	assign enter_stop = state_r == ST_RUN && entry_pend_r && CPU_QUIESCE
		&& psc_r[PSC_STOP_POS] && CPU_CLK_IS_MAIN;
	assign enter_idle = state_r == ST_RUN && entry_pend_r && CPU_QUIESCE
		&& !psc_r[PSC_STOP_POS] && psc_r[PSC_IDLE_POS];

	assign irq_wake = |(IRQ_REQ & ~IRQ_MASK);
	assign wake = NMI_REQ || irq_wake;
	assign settle_start = state_r == ST_STOP && wake;
	assign resume = (state_r == ST_SETTLE && settle_done)
		|| (state_r == ST_IDLE && wake);
	assign settle_exp = SETTLE_EXP_BASE + {2'b00, osc_settle_select_reg_r};

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_RUN:
				if (enter_stop)
					state_nxt = ST_STOP;
				else if (enter_idle)
					state_nxt = ST_IDLE;
			ST_IDLE:
				if (wake)
					state_nxt = ST_RUN;
			ST_STOP:
				if (wake)
					state_nxt = ST_SETTLE;
			ST_SETTLE:
				if (settle_done)
					state_nxt = ST_RUN;
			default:
				state_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			state_r <= ST_RUN;
		else
			state_r <= state_nxt;
	end

	smws_settle_counter u_settle (
		.clk(REF_CLK),
		.srst(SRST),
		.start(settle_start),
		.exp_sel(settle_exp),
		.running(settle_run),
		.done(settle_done)
	);

	////////////////////////////////////////////////////////////////////////
	// clock gating outputs
	assign MAIN_OSC_EN = state_r != ST_STOP && state_r != ST_SETTLE;
	assign SUB_OSC_EN = 1'b1;
	assign CPU_CLK_EN = state_r == ST_RUN;

	genvar gi;
	generate
		for (gi = 0; gi < UART_N; gi++)
		begin : g_uart
			assign PERIPH_EN.uart_tx[gi] = state_r == ST_RUN
				|| state_r == ST_IDLE
				|| cfg_r[CFG_ASYNC_SERIAL_CH0_EXT_POS + gi];
			assign PERIPH_EN.uart_rx[gi] = state_r == ST_RUN
				|| state_r == ST_IDLE;
		end
	endgenerate
	assign PERIPH_EN.clocked_serial_ch4 = state_r == ST_RUN || state_r == ST_IDLE
		|| cfg_r[CFG_CLOCKED_SERIAL_CH4_EXT_POS];
	assign PERIPH_EN.other = state_r == ST_RUN || state_r == ST_IDLE;

	////////////////////////////////////////////////////////////////////////
	// handler branch one cycle after the clock comes back, never with it
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			resume_r <= 1'b0;
			vec_pend_r <= 1'b0;
		end
		else
		begin
			resume_r <= resume;
			vec_pend_r <= resume_r;
		end
	end
	assign VECTOR_GO = vec_pend_r;

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			wake_nmi_r <= 1'b0;
		else if (settle_start || (state_r == ST_IDLE && wake))
			wake_nmi_r <= NMI_REQ;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			from_ext_r <= 1'b0;
		else if (enter_stop || enter_idle)
			from_ext_r <= EXEC_EXT_MEM;
	end

	assign IRQ_HOLD = PSW_IN.np || PSW_IN.id || PSW_IN.ei_cleared;

	// sticky until software clears it; a new hazard wins over the clear
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			hazard_r <= 1'b0;
		else if (vec_pend_r && from_ext_r && IRQ_HOLD)
			hazard_r <= 1'b1;
		else if (wr_strobe && WB_ADR_I == ADDR_STAT && WB_DAT_I[STAT_HAZARD_POS])
			hazard_r <= 1'b0;
	end
	assign PC_HAZARD = hazard_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);

	sequence s_clock_back;
		CPU_CLK_EN && !VECTOR_GO ##1 VECTOR_GO;
	endsequence

	property p_stop_entry;
		state_r == ST_RUN && entry_pend_r && CPU_QUIESCE
			&& psc_r[PSC_STOP_POS] && CPU_CLK_IS_MAIN |=> state_r == ST_STOP;
	endproperty
	a_stop_entry: assert property (p_stop_entry)
		else $error("stop not entered");

	property p_stop_clocks;
		state_r == ST_STOP |-> !MAIN_OSC_EN && !CPU_CLK_EN && SUB_OSC_EN
			&& !PERIPH_EN.other;
	endproperty
	a_stop_clocks: assert property (p_stop_clocks)
		else $error("clock left running in stop");

	property p_uart_stop;
		state_r == ST_STOP |-> PERIPH_EN.uart_rx == 2'b00
			&& PERIPH_EN.uart_tx[0] == cfg_r[CFG_ASYNC_SERIAL_CH0_EXT_POS];
	endproperty
	a_uart_stop: assert property (p_uart_stop)
		else $error("uart enable wrong in stop");

	property p_clocked_serial_ch4_stop;
		state_r == ST_STOP |-> PERIPH_EN.clocked_serial_ch4 == cfg_r[CFG_CLOCKED_SERIAL_CH4_EXT_POS];
	endproperty
	a_clocked_serial_ch4_stop: assert property (p_clocked_serial_ch4_stop)
		else $error("clocked_serial_ch4 enable wrong in stop");

	property p_wake;
		state_r == ST_STOP && (NMI_REQ || irq_wake) |=> state_r == ST_SETTLE
			&& settle_run;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake did not start settling");

	property p_settle_gated;
		state_r == ST_SETTLE && !settle_done |=> !CPU_CLK_EN;
	endproperty
	a_settle_gated: assert property (p_settle_gated)
		else $error("cpu clock on while settling");

	property p_resume;
		state_r == ST_SETTLE && settle_done |=> s_clock_back;
	endproperty
	a_resume: assert property (p_resume)
		else $error("resume order wrong");

	property p_quiesce;
		$rose(state_r == ST_STOP || state_r == ST_IDLE) |-> $past(CPU_QUIESCE);
	endproperty
	a_quiesce: assert property (p_quiesce)
		else $error("power save entered before drain");

	property p_hold;
		VECTOR_GO && from_ext_r
			&& (PSW_IN.np || PSW_IN.id || PSW_IN.ei_cleared) |=> PC_HAZARD;
	endproperty
	a_hold: assert property (p_hold)
		else $error("irq hold wrong");

endmodule : smws_top
`default_nettype wire

// *** bench/smws_top_tb.sv ***
// self-checking bench for the stop-mode wake sequencer
`timescale 1ns/100ps
`default_nettype none
module smws_top_tb
	import smws_pkg::*;
;
	logic ref_clk;
	logic srst;
	logic cyc;
	logic stb;
	logic we;
	logic [4:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w;
	logic [31:0] dat_r;
	logic ack;
	logic clk_main;
	logic quiesce;
	logic ext_mem;
	logic nmi;
	logic [IRQ_W-1:0] irq;
	logic [IRQ_W-1:0] mask;
	smws_psw_t program_status_word;
	logic main_osc;
	logic sub_osc;
	logic cpu_clk;
	smws_periph_en_t periph;
	logic vgo;
	logic hold;
	logic hazard;
	int bad_count;
	int n_checks;
	logic [31:0] rd;

	// short settling base keeps the run brief: 2^(2+osc_settle_select_reg)
	smws_top #(.VARIANT_LONG(1'b0), .SETTLE_EXP_BASE(5'h02)) uut (
		.REF_CLK(ref_clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w),
		.WB_DAT_O(dat_r), .WB_ACK_O(ack), .CPU_CLK_IS_MAIN(clk_main),
		.CPU_QUIESCE(quiesce), .EXEC_EXT_MEM(ext_mem), .NMI_REQ(nmi),
		.IRQ_REQ(irq), .IRQ_MASK(mask), .PSW_IN(program_status_word),
		.MAIN_OSC_EN(main_osc), .SUB_OSC_EN(sub_osc), .CPU_CLK_EN(cpu_clk),
		.PERIPH_EN(periph), .VECTOR_GO(vgo), .IRQ_HOLD(hold),
		.PC_HAZARD(hazard)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		sel <= 4'hf;
		// no cycle limit here: only the watchdog ends a stuck access
		do
		begin
			@(posedge ref_clk);
		end
		while (ack !== 1'b1);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic enter(input logic [31:0] power_save_ctrl_reg);
		wb(1'b1, ADDR_PROT_CMD, 32'h0000_005a);
		wb(1'b1, ADDR_PSC, power_save_ctrl_reg);
	endtask : enter

	// wake and count gated cycles; the irq is toggled mid-count
	task automatic wake(input logic by_nmi, input int n_exp);
		int n;
		n = 0;
		@(posedge ref_clk);
		if (by_nmi)
			nmi <= 1'b1;
		else
			mask <= 8'h00;
		do
		begin
			@(posedge ref_clk);
			if (!by_nmi && n == 3)
				irq <= 8'h00;
			if (!by_nmi && n == 4)
				irq <= 8'h01;
			@(negedge ref_clk);
			n++;
		end
		while (cpu_clk !== 1'b1 && n < 300);
		chk(32'(n >= n_exp && n <= n_exp + 5), 32'h1);
		if (n_exp > 0)
		begin
			chk(32'(vgo), 32'h0);
			@(negedge ref_clk);
			chk(32'(vgo), 32'h1);
		end
		@(posedge ref_clk);
		nmi <= 1'b0;
		irq <= 8'h00;
	endtask : wake

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		close_out();
	end

	initial
	begin
		bad_count = 0;
		n_checks = 0;
		srst = 1'b1;
		{cyc, stb, we, adr, sel, dat_w} = '0;
		clk_main = 1'b1;
		quiesce = 1'b1;
		ext_mem = 1'b0;
		nmi = 1'b0;
		irq = 8'h00;
		mask = 8'hff;
		program_status_word = '0;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		chk({main_osc, sub_osc, cpu_clk, vgo, hazard}, 32'h1c);
		chk(32'(periph), 32'h3f);
		wb(1'b0, ADDR_OSC_SETTLE_SELECT_REG, '0);
		chk(rd, {29'h0, OSC_SETTLE_SELECT_REG_RST_SHORT});
		wb(1'b0, 5'h14, '0);
		chk(rd, 32'h0);
		// unprotected store, then a store broken by another write
		wb(1'b1, ADDR_PSC, 32'h2);
		wb(1'b0, ADDR_STAT, '0);
		chk(rd & 32'h2f, 32'h21);
		wb(1'b1, ADDR_STAT, 32'h20);
		wb(1'b1, ADDR_PROT_CMD, 32'h0);
		wb(1'b1, ADDR_CFG, 32'h5);
		wb(1'b1, ADDR_PSC, 32'h2);
		wb(1'b0, ADDR_STAT, '0);
		chk(rd & 32'h2f, 32'h21);
		wb(1'b1, ADDR_STAT, 32'h20);
		wb(1'b1, ADDR_OSC_SETTLE_SELECT_REG, 32'h1);
		// stop waits for quiesce and main clock as cpu clock
		@(posedge ref_clk);
		quiesce <= 1'b0;
		clk_main <= 1'b0;
		enter(32'h2);
		repeat (4) @(posedge ref_clk);
		wb(1'b0, ADDR_STAT, '0);
		chk(rd & 32'h0f, 32'h1);
		quiesce <= 1'b1;
		wb(1'b0, ADDR_STAT, '0);
		chk(rd & 32'h0f, 32'h1);
		clk_main <= 1'b1;
		irq <= 8'h01;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({main_osc, sub_osc, cpu_clk}, 32'h2);
		chk(32'(periph), 32'h12);
		wake(1'b0, 9);
		wb(1'b0, ADDR_STAT, '0);
		chk(rd & 32'h5f, 32'h1);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge ref_clk);
			program_status_word <= 3'(i);
			@(negedge ref_clk);
			chk(32'(hold), 32'(i != 0));
		end
		// nmi wake from external memory with a held request
		wb(1'b1, ADDR_OSC_SETTLE_SELECT_REG, 32'h2);
		ext_mem <= 1'b1;
		program_status_word <= 3'b010;
		enter(32'h2);
		repeat (3) @(posedge ref_clk);
		wake(1'b1, 17);
		@(negedge ref_clk);
		chk(32'(hazard), 32'h1);
		wb(1'b0, ADDR_STAT, '0);
		chk(rd & 32'h5f, 32'h51);
		wb(1'b1, ADDR_STAT, 32'h10);
		@(negedge ref_clk);
		chk(32'(hazard), 32'h0);
		// idle wake without settling, no held request: no hazard
		program_status_word <= 3'b000;
		mask <= 8'hff;
		irq <= 8'h02;
		enter(32'h1);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({main_osc, cpu_clk}, 32'h2);
		wake(1'b0, 0);
		repeat (2) @(negedge ref_clk);
		chk(32'(hazard), 32'h0);
		close_out();
	end
endmodule : smws_top_tb
`default_nettype wire
